// ### core/shared_io_map.vh
// Register map and reset constants of the shared two-core parallel port.
// Assumes byte addresses on a 32-bit APB, one aligned word per register.
`ifndef SHARED_IO_MAP_VH
`define SHARED_IO_MAP_VH

// Byte distance between the register groups of two ports
`define IO_PORT_STRIDE 12'h0040
// Register offsets inside one port group
`define IO_DIR_OFS 12'h0000
`define IO_DIR_SET_OFS 12'h0004
`define IO_DIR_CLR_OFS 12'h0008
`define IO_DIR_INV_OFS 12'h000C
`define IO_LAT_OFS 12'h0010
`define IO_LAT_SET_OFS 12'h0014
`define IO_LAT_CLR_OFS 12'h0018
`define IO_LAT_INV_OFS 12'h001C
`define IO_LEVEL_OFS 12'h0020
`define IO_VALID_OFS 12'h0024
`define IO_OWNER_OFS 12'h0028
`define IO_DRIVE_OFS 12'h002C
// Number of registers in one port group
`define IO_REG_COUNT 4'hC
// Field positions of the word address
`define IO_REG_LSB 2
`define IO_PORT_LSB 6
`define IO_TOP_LSB 10
// Reset values, one bit of each field
`define IO_DIR_RST_BIT 1'b1
`define IO_LAT_RST_BIT 1'b0
`define IO_OWN_RST_BIT 1'b0
// Write kinds in the low two register index bits
`define IO_OP_PUT 2'h0
`define IO_OP_SET 2'h1
`define IO_OP_CLR 2'h2
`define IO_OP_INV 2'h3

`endif

// ### core/pin_sync.v
// Three-stage synchroniser for the pin inputs.
// Assumes asynchronous pin levels; the output follows once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter WIDTH = 16
) (
  // Clock and reset
  input wire I_CLK,
  input wire I_SRST,
  // Raw and filtered levels
  input wire [WIDTH-1:0] I_RAW,
  output reg [WIDTH-1:0] O_LEVEL
);

  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;
  reg [WIDTH-1:0] stage3;

  // Stage one feeds stage two only, so a metastable bit never reaches the compare
  always @(posedge I_CLK) begin
    if (I_SRST) begin
      stage1 <= {WIDTH{1'b0}};
      stage2 <= {WIDTH{1'b0}};
      stage3 <= {WIDTH{1'b0}};
      O_LEVEL <= {WIDTH{1'b0}};
    end else begin
      stage1 <= I_RAW;
      stage2 <= stage1;
      stage3 <= stage2;
      O_LEVEL <= (stage2 & stage3) | (O_LEVEL & (stage2 ^ stage3));
    end
  end

endmodule // pin_sync

`default_nettype wire

// ### core/shared_io_port.v
// Parallel I/O port shared by two processor cores, with peripheral override.
// Assumes two APB slaves (one per core), same clock, pins buffered by the pad ring.
//
// Notes on behaviour
// [R1] Each synchronised pin level is delivered to both cores alike.
// [R2] An ownership bit per pin gives that pin's output to exactly one core.
// [R3] Each core has its own port registers in its own APB space, same port count.
// [R4] Pin data and enable come from the peripheral first, the port second.
// [R5] A port's own driven value is never looped back into the peripheral input.
// [R6] An enabled, driving peripheral disables the port driver yet the pin stays readable.
// [R7] An enabled peripheral that is not driving lets the port drive the pin.
// [R8] Direction bit one makes the pin an input, zero an output.
// [R9] Reset sets every direction bit so all pins are inputs.
// [R10] The latch register reads back the latch and writes the latch.
// [R11] The level register reads the pins and a write to it updates the latch.
// [R12] Bits absent on a variant are disabled and their latch, direction and level read zero.
// [R13] A pin whose peripheral is input only acts as a plain port pin.
// [R14] Each port group holds twelve registers for its digital operation.
// [R15] The non-owning core's direction and latch never reach the pin driver.
// [R16] An owning core set to output drives its latch unless a peripheral drives the pin.
//
// Local design decisions: the register offsets and the APB interface to the registers.
`include "shared_io_map.vh"
`timescale 1ns/1ps
`default_nettype none

module shared_io_port #(
  parameter WIDTH = 16,
  parameter NPORTS = 5,
  parameter [NPORTS*WIDTH-1:0] VALID = {NPORTS*WIDTH{1'b1}}
) (
  // Clock and reset
  input wire I_CLK,
  input wire I_SRST,
  // APB slave of the first core
  input wire I_A_PSEL,
  input wire I_A_PENABLE,
  input wire I_A_PWRITE,
  input wire [11:0] I_A_PADDR,
  input wire [31:0] I_A_PWDATA,
  output reg [31:0] O_A_PRDATA,
  output wire O_A_PREADY,
  output reg O_A_PSLVERR,
  // APB slave of the second core
  input wire I_B_PSEL,
  input wire I_B_PENABLE,
  input wire I_B_PWRITE,
  input wire [11:0] I_B_PADDR,
  input wire [31:0] I_B_PWDATA,
  output reg [31:0] O_B_PRDATA,
  output wire O_B_PREADY,
  output reg O_B_PSLVERR,
  // Pad signals, enable low while the pad is driven
  input wire [NPORTS*WIDTH-1:0] I_PIN,
  output reg [NPORTS*WIDTH-1:0] O_PIN,
  output reg [NPORTS*WIDTH-1:0] O_PIN_OE_N,
  // Peripherals sharing the pins
  input wire [NPORTS*WIDTH-1:0] I_PERI_EN,
  input wire [NPORTS*WIDTH-1:0] I_PERI_DRIVE,
  input wire [NPORTS*WIDTH-1:0] I_PERI_OUT,
  output reg [NPORTS*WIDTH-1:0] O_PERI_IN
);

  localparam N = NPORTS * WIDTH;

  // Per-core direction and latch, shared ownership
  reg [N-1:0] dir_a;
  reg [N-1:0] dir_b;
  reg [N-1:0] lat_a;
  reg [N-1:0] lat_b;
  reg [N-1:0] owner;

  wire [N-1:0] pin_level;
  wire [N-1:0] peri_act;
  reg [N-1:0] own_dir;
  reg [N-1:0] own_lat;
  reg [N-1:0] port_drv;

  wire a_map;
  wire b_map;
  wire a_wr;
  wire b_wr;
  wire [3:0] a_port;
  wire [3:0] b_port;
  wire [3:0] a_reg;
  wire [3:0] b_reg;
  reg [31:0] next_a_rdata;
  reg [31:0] next_b_rdata;
  integer p;

  // True when the address lands on one of the twelve registers of an existing port
  function mapped;
    input [11:0] addr;
    begin
      mapped = (addr[11:`IO_TOP_LSB] == 2'h0) &&
               ({28'h0000_000, addr[`IO_TOP_LSB-1:`IO_PORT_LSB]} < NPORTS) &&
               (addr[`IO_PORT_LSB-1:`IO_REG_LSB] < `IO_REG_COUNT); // [R14]
    end
  endfunction

  // Applies a plain, set, clear or invert write to one port field
  function [WIDTH-1:0] upd;
    input [WIDTH-1:0] old;
    input [WIDTH-1:0] wd;
    input [1:0] op;
    begin
      case (op)
        `IO_OP_PUT: upd = wd;
        `IO_OP_SET: upd = old | wd;
        `IO_OP_CLR: upd = old & ~wd;
        `IO_OP_INV: upd = old ^ wd;
        default: upd = old;
      endcase
    end
  endfunction

  // Read word of one port group seen from one core
  function [31:0] rdmux;
    input [3:0] rg;
    input [WIDTH-1:0] d;
    input [WIDTH-1:0] l;
    input [WIDTH-1:0] lv;
    input [WIDTH-1:0] v;
    input [WIDTH-1:0] o;
    input [WIDTH-1:0] dr;
    reg [WIDTH-1:0] f;
    begin
      f = {WIDTH{1'b0}};
      case (rg)
        4'h0, 4'h1, 4'h2, 4'h3: f = d & v; // [R12]
        4'h4, 4'h5, 4'h6, 4'h7: f = l & v; // [R10] [R12]
        4'h8: f = lv & v; // [R11] [R12]
        4'h9: f = v;
        4'hA: f = o & v;
        4'hB: f = dr;
        default: f = {WIDTH{1'b0}};
      endcase
      rdmux = {{(32-WIDTH){1'b0}}, f};
    end
  endfunction

  // One synchroniser serves both cores, so both always see the same level
  pin_sync #(
    .WIDTH(N)
  ) u_sync (
    .I_CLK(I_CLK),
    .I_SRST(I_SRST),
    .I_RAW(I_PIN),
    .O_LEVEL(pin_level)
  ); // [R1]

  // Address decode of both slaves
  assign a_map = mapped(I_A_PADDR);
  assign b_map = mapped(I_B_PADDR);
  assign a_port = I_A_PADDR[`IO_TOP_LSB-1:`IO_PORT_LSB];
  assign b_port = I_B_PADDR[`IO_TOP_LSB-1:`IO_PORT_LSB];
  assign a_reg = I_A_PADDR[`IO_PORT_LSB-1:`IO_REG_LSB];
  assign b_reg = I_B_PADDR[`IO_PORT_LSB-1:`IO_REG_LSB];
  // Zero wait states; writes land at the access edge
  assign O_A_PREADY = 1'b1;
  assign O_B_PREADY = 1'b1;
  assign a_wr = I_A_PSEL & I_A_PENABLE & I_A_PWRITE & a_map;
  assign b_wr = I_B_PSEL & I_B_PENABLE & I_B_PWRITE & b_map;

  // First core registers; ownership is writable from this core only
  always @(posedge I_CLK) begin
    if (I_SRST) begin
      dir_a <= {N{`IO_DIR_RST_BIT}}; // [R9]
      lat_a <= {N{`IO_LAT_RST_BIT}};
      owner <= {N{`IO_OWN_RST_BIT}};
    end else if (a_wr) begin
      for (p = 0; p < NPORTS; p = p + 1) begin
        if (a_port == p[3:0]) begin
          case (a_reg)
            4'h0, 4'h1, 4'h2, 4'h3:
              dir_a[p*WIDTH +: WIDTH] <= upd(dir_a[p*WIDTH +: WIDTH],
                I_A_PWDATA[WIDTH-1:0], a_reg[1:0]) & VALID[p*WIDTH +: WIDTH]; // [R12]
            4'h4, 4'h5, 4'h6, 4'h7:
              lat_a[p*WIDTH +: WIDTH] <= upd(lat_a[p*WIDTH +: WIDTH],
                I_A_PWDATA[WIDTH-1:0], a_reg[1:0]) & VALID[p*WIDTH +: WIDTH]; // [R10]
            4'h8:
              lat_a[p*WIDTH +: WIDTH] <= I_A_PWDATA[WIDTH-1:0] &
                VALID[p*WIDTH +: WIDTH]; // [R11]
            4'hA:
              owner[p*WIDTH +: WIDTH] <= I_A_PWDATA[WIDTH-1:0] &
                VALID[p*WIDTH +: WIDTH]; // [R2]
            default: begin
            end
          endcase
        end
      end
    end
  end

  // Second core registers, its own copy of direction and latch
  always @(posedge I_CLK) begin
    if (I_SRST) begin
      dir_b <= {N{`IO_DIR_RST_BIT}}; // [R9]
      lat_b <= {N{`IO_LAT_RST_BIT}};
    end else if (b_wr) begin
      for (p = 0; p < NPORTS; p = p + 1) begin
        if (b_port == p[3:0]) begin
          case (b_reg)
            4'h0, 4'h1, 4'h2, 4'h3:
              dir_b[p*WIDTH +: WIDTH] <= upd(dir_b[p*WIDTH +: WIDTH],
                I_B_PWDATA[WIDTH-1:0], b_reg[1:0]) & VALID[p*WIDTH +: WIDTH]; // [R3]
            4'h4, 4'h5, 4'h6, 4'h7:
              lat_b[p*WIDTH +: WIDTH] <= upd(lat_b[p*WIDTH +: WIDTH],
                I_B_PWDATA[WIDTH-1:0], b_reg[1:0]) & VALID[p*WIDTH +: WIDTH]; // [R10]
            4'h8:
              lat_b[p*WIDTH +: WIDTH] <= I_B_PWDATA[WIDTH-1:0] &
                VALID[p*WIDTH +: WIDTH]; // [R11]
            default: begin
            end
          endcase
        end
      end
    end
  end

  // Pin ownership and driver selection
  assign peri_act = I_PERI_EN & I_PERI_DRIVE & VALID; // [R6] [R13]

  always @* begin
    own_dir = (owner & dir_b) | (~owner & dir_a); // [R2] [R15]
    own_lat = (owner & lat_b) | (~owner & lat_a); // [R15]
    // Clear direction means output; a driving peripheral takes the pin away
    port_drv = ~own_dir & ~peri_act & VALID; // [R7] [R8] [R16]
  end

  // Pad drive is registered so the pads never see decode glitches
  always @(posedge I_CLK) begin
    if (I_SRST) begin
      O_PIN <= {N{1'b0}};
      O_PIN_OE_N <= {N{1'b1}};
      O_PERI_IN <= {N{1'b0}};
    end else begin
      O_PIN <= (peri_act & I_PERI_OUT) | (~peri_act & own_lat); // [R4] [R16]
      O_PIN_OE_N <= ~(peri_act | port_drv); // [R4] [R6]
      // Bits the port drives itself read low at the peripheral
      O_PERI_IN <= pin_level & ~port_drv & VALID; // [R5]
    end
  end

  // Read data is taken in the setup phase and held through the access phase
  always @* begin
    next_a_rdata = 32'h0000_0000;
    next_b_rdata = 32'h0000_0000;
    if (a_map) begin
      next_a_rdata = rdmux(a_reg, dir_a[a_port*WIDTH +: WIDTH],
        lat_a[a_port*WIDTH +: WIDTH], pin_level[a_port*WIDTH +: WIDTH],
        VALID[a_port*WIDTH +: WIDTH], owner[a_port*WIDTH +: WIDTH],
        port_drv[a_port*WIDTH +: WIDTH] & ~owner[a_port*WIDTH +: WIDTH]); // [R1]
    end
    if (b_map) begin
      next_b_rdata = rdmux(b_reg, dir_b[b_port*WIDTH +: WIDTH],
        lat_b[b_port*WIDTH +: WIDTH], pin_level[b_port*WIDTH +: WIDTH],
        VALID[b_port*WIDTH +: WIDTH], owner[b_port*WIDTH +: WIDTH],
        port_drv[b_port*WIDTH +: WIDTH] & owner[b_port*WIDTH +: WIDTH]); // [R1] [R3]
    end
  end

  // Bus answers; an unmapped address gets an error and zero data
  always @(posedge I_CLK) begin
    if (I_SRST) begin
      O_A_PRDATA <= 32'h0000_0000;
      O_A_PSLVERR <= 1'b0;
      O_B_PRDATA <= 32'h0000_0000;
      O_B_PSLVERR <= 1'b0;
    end else begin
      if (I_A_PSEL & ~I_A_PENABLE) begin
        O_A_PRDATA <= I_A_PWRITE ? 32'h0000_0000 : next_a_rdata;
        O_A_PSLVERR <= ~a_map;
      end
      if (I_B_PSEL & ~I_B_PENABLE) begin
        O_B_PRDATA <= I_B_PWRITE ? 32'h0000_0000 : next_b_rdata;
        O_B_PSLVERR <= ~b_map;
      end
    end
  end

endmodule // shared_io_port

`default_nettype wire

// ### bench/shared_io_port_assertions.sv
// Checker for the shared two-core port: pad control, peripheral priority, APB errors.
// Assumes it is bound to every shared_io_port instance, one clock, sync reset.
`timescale 1ns/1ps
`default_nettype none
module shared_io_port_checker #(
  parameter WIDTH = 16,
  parameter NPORTS = 5,
  parameter N = NPORTS*WIDTH,
  parameter [N-1:0] VALID = {N{1'b1}}
) (
  // Clock and reset
  input wire I_CLK,
  input wire I_SRST,
  // Register buses
  input wire I_A_PSEL,
  input wire I_A_PENABLE,
  input wire [11:0] I_A_PADDR,
  input wire [31:0] O_A_PRDATA,
  input wire O_A_PREADY,
  input wire O_A_PSLVERR,
  input wire I_B_PSEL,
  input wire I_B_PENABLE,
  input wire [11:0] I_B_PADDR,
  input wire O_B_PREADY,
  input wire O_B_PSLVERR,
  // Pads and peripherals
  input wire [N-1:0] O_PIN,
  input wire [N-1:0] O_PIN_OE_N,
  input wire [N-1:0] I_PERI_EN,
  input wire [N-1:0] I_PERI_DRIVE,
  input wire [N-1:0] I_PERI_OUT,
  input wire [N-1:0] O_PERI_IN
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_SRST);

  a_ready_const: assert property (O_A_PREADY && O_B_PREADY)
    else $error("ready dropped");
  a_reset_inputs: assert property ($past(I_SRST) |-> (&O_PIN_OE_N && O_PIN == '0))
    else $error("pads not released after reset");
  a_peri_wins: assert property (!$past(I_SRST) |-> (((O_PIN_OE_N | (O_PIN ^ $past(I_PERI_OUT)))
    & $past(I_PERI_EN) & $past(I_PERI_DRIVE) & VALID) == '0))
    else $error("active peripheral does not own its pad");
  a_no_loop: assert property (((O_PERI_IN & ~O_PIN_OE_N
    & ~($past(I_PERI_EN) & $past(I_PERI_DRIVE))) == '0))
    else $error("port output looped into peripheral");
  a_absent_idle: assert property ((((~O_PIN_OE_N) | O_PIN) & ~VALID) == '0)
    else $error("absent bit driven");
  a_a_unmapped: assert property (I_A_PSEL && !I_A_PENABLE && I_A_PADDR[11:10] != 2'h0
    |=> O_A_PSLVERR && O_A_PRDATA == 32'h0000_0000)
    else $error("unmapped access not refused");
  a_b_badreg: assert property (I_B_PSEL && !I_B_PENABLE && I_B_PADDR[5:2] > 4'hB
    |=> O_B_PSLVERR)
    else $error("register past the group not refused");
  a_a_mapped: assert property (I_A_PSEL && !I_A_PENABLE && I_A_PADDR[11:10] == 2'h0
    && I_A_PADDR[9:6] < NPORTS && I_A_PADDR[5:2] < 4'hC |=> !O_A_PSLVERR)
    else $error("mapped access refused");
endmodule // shared_io_port_checker

bind shared_io_port shared_io_port_checker #(.WIDTH(WIDTH), .NPORTS(NPORTS), .VALID(VALID)) chk_u (
  .I_CLK(I_CLK), .I_SRST(I_SRST), .I_A_PSEL(I_A_PSEL), .I_A_PENABLE(I_A_PENABLE),
  .I_A_PADDR(I_A_PADDR), .O_A_PRDATA(O_A_PRDATA), .O_A_PREADY(O_A_PREADY),
  .O_A_PSLVERR(O_A_PSLVERR), .I_B_PSEL(I_B_PSEL), .I_B_PENABLE(I_B_PENABLE),
  .I_B_PADDR(I_B_PADDR), .O_B_PREADY(O_B_PREADY), .O_B_PSLVERR(O_B_PSLVERR),
  .O_PIN(O_PIN), .O_PIN_OE_N(O_PIN_OE_N), .I_PERI_EN(I_PERI_EN),
  .I_PERI_DRIVE(I_PERI_DRIVE), .I_PERI_OUT(I_PERI_OUT), .O_PERI_IN(O_PERI_IN));
`default_nettype wire

// ### bench/pad_model.sv
// Outside circuit on the shared pads: the pad follows the port while driven.
// Assumes a low enable means the device drives; otherwise the board level shows.
`timescale 1ns/1ps
`default_nettype none
module pad_model #(
  parameter N = 8
) (
  // Device side
  input wire logic [N-1:0] i_out,
  input wire logic [N-1:0] i_oe_n,
  // Board level seen on released pads
  input wire logic [N-1:0] i_ext,
  output logic [N-1:0] o_pad
);
  assign o_pad = (~i_oe_n & i_out) | (i_oe_n & i_ext);
endmodule // pad_model
`default_nettype wire

// ### bench/test_shared_io_port.sv
// Testbench for shared_io_port: two APB masters, peripheral stimulus, pad model.
// Assumes a 2-port, 4-bit build with the top bit of the second port absent.
`include "shared_io_map.vh"
`timescale 1ns/1ps
`default_nettype none
module test_shared_io_port;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [1:0] psel = 2'h0, pen = 2'h0, pwr = 2'h0;
  logic [11:0] pa [2] = '{12'h000, 12'h000};
  logic [31:0] pwd [2] = '{32'h0000_0000, 32'h0000_0000};
  wire [31:0] prd [2];
  wire [1:0] prdy, perr;
  logic [7:0] peri_en = 8'h00, peri_drv = 8'h00, peri_out = 8'h00, ext = 8'h00;
  wire [7:0] pad, opin, oe_n, peri_in;
  logic [31:0] rdat;
  logic rerr;
  int n_fail = 0, n_tests = 0;

  always #20 clk = ~clk;

  shared_io_port #(.WIDTH(4), .NPORTS(2), .VALID(8'h7F)) dut_u (
    .I_CLK(clk), .I_SRST(srst),
    .I_A_PSEL(psel[0]), .I_A_PENABLE(pen[0]), .I_A_PWRITE(pwr[0]), .I_A_PADDR(pa[0]),
    .I_A_PWDATA(pwd[0]), .O_A_PRDATA(prd[0]), .O_A_PREADY(prdy[0]), .O_A_PSLVERR(perr[0]),
    .I_B_PSEL(psel[1]), .I_B_PENABLE(pen[1]), .I_B_PWRITE(pwr[1]), .I_B_PADDR(pa[1]),
    .I_B_PWDATA(pwd[1]), .O_B_PRDATA(prd[1]), .O_B_PREADY(prdy[1]), .O_B_PSLVERR(perr[1]),
    .I_PIN(pad), .O_PIN(opin), .O_PIN_OE_N(oe_n), .I_PERI_EN(peri_en),
    .I_PERI_DRIVE(peri_drv), .I_PERI_OUT(peri_out), .O_PERI_IN(peri_in));

  pad_model #(.N(8)) pad_u (.i_out(opin), .i_oe_n(oe_n), .i_ext(ext), .o_pad(pad));

  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // One APB transfer; an idle edge first keeps back-to-back calls race free
  task automatic acc(input int c, input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel[c] <= 1'b1; pwr[c] <= w; pa[c] <= a; pwd[c] <= d;
    @(posedge clk);
    pen[c] <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (prdy[c] !== 1'b1 && k < 50);
    if (k >= 50) begin
      n_fail++;
      tally_and_finish();
    end
    rdat = prd[c];
    rerr = perr[c];
    psel[c] <= 1'b0;
    pen[c] <= 1'b0;
  endtask

  task automatic wr(input int c, input logic [11:0] a, input logic [31:0] d);
    acc(c, 1'b1, a, d);
  endtask

  task automatic rd(input int c, input logic [11:0] a, input logic [31:0] exp);
    acc(c, 1'b0, a, 32'h0000_0000);
    chk(rdat, exp);
    chk(rerr, 1'b0);
  endtask

  task automatic bad(input int c, input logic [11:0] a);
    acc(c, 1'b0, a, 32'h0000_0000);
    chk(rdat, 32'h0000_0000);
    chk(rerr, 1'b1);
  endtask

  initial begin
    cyc(3);
    srst <= 1'b0;
    cyc(8);
    chk(oe_n, 8'hFF);
    rd(0, `IO_DIR_OFS, 4'hF);
    rd(0, 12'h040, 4'h7);
    ext <= 8'hA5;
    cyc(8);
    rd(0, `IO_LEVEL_OFS, 4'h5);
    rd(1, `IO_LEVEL_OFS, 4'h5);
    rd(1, 12'h060, 4'h2);
    wr(0, `IO_LAT_OFS, 4'h9);
    wr(0, `IO_DIR_OFS, 4'h0);
    cyc(2);
    chk(opin[3:0], 4'h9);
    chk(oe_n[3:0], 4'h0);
    rd(0, `IO_LAT_OFS, 4'h9);
    rd(1, `IO_DIR_OFS, 4'hF);
    cyc(8);
    rd(1, `IO_LEVEL_OFS, 4'h9);
    wr(0, `IO_LEVEL_OFS, 4'h6);
    cyc(2);
    chk(opin[3:0], 4'h6);
    rd(0, `IO_LAT_OFS, 4'h6);
    wr(1, `IO_LAT_OFS, 4'h3);
    wr(1, `IO_DIR_OFS, 4'h0);
    cyc(2);
    chk(opin[3:0], 4'h6);
    wr(0, `IO_OWNER_OFS, 4'hF);
    cyc(2);
    chk(opin[3:0], 4'h3);
    // Peripheral drives bits 1:0 only; bits 3:2 stay with the owning port
    peri_en <= 8'h0F; peri_drv <= 8'h03; peri_out <= 8'h01;
    cyc(2);
    chk(opin[3:0], 4'h1);
    chk(oe_n[3:0], 4'h0);
    cyc(8);
    chk(peri_in[3:0], 4'h1);
    rd(1, `IO_LEVEL_OFS, 4'h1);
    peri_drv <= 8'h00;
    cyc(2);
    chk(opin[3:0], 4'h3);
    rd(1, 12'h064, 4'h7);
    bad(0, 12'h400);
    bad(1, 12'h080);
    bad(0, 12'h030);
    bad(1, 12'h034);
    rd(1, `IO_OWNER_OFS, 4'hF);
    wr(1, `IO_DIR_SET_OFS, 4'h4);
    rd(1, `IO_DIR_OFS, 4'h4);
    rd(1, `IO_DRIVE_OFS, 4'hB);
    // A second reset in mid-run must release every pad again
    srst <= 1'b1;
    cyc(3);
    srst <= 1'b0;
    cyc(2);
    chk(oe_n, 8'hFF);
    rd(1, `IO_DIR_OFS, 4'hF);
    tally_and_finish();
  end
endmodule // test_shared_io_port
`default_nettype wire
